// ==== hw/epd_ctrl_map.vh ====
// Constants for the display-segment driver control logic: link id, register
// offsets, control-byte fields and timing counts.
// Assumes a 10 MHz system clock; the serial clock is sampled, not used as a clock.
// Function
// - Channels 1-36 segment, 37-38 background, 39-40 common
// - Bit one gives high level, zero gives 0V
// - Registers 0-4 hold eight channels, LSB first
// - Six byte registers, control byte at five
// - Pump enable bit switches charge pump
// - Half-level bit picks half rail for highs
// - Load bit high copies channels into staging
// - Load bit low latches staging onto outputs
// - Two-bit field selects pump reference voltage
// - Identity byte: fixed prefix plus address pins
// - Address byte then data byte follow identity
// - Device acknowledges each byte low
// - Up to four devices, distinct address pins
`ifndef EPD_CTRL_MAP_VH
`define EPD_CTRL_MAP_VH

// Identity prefix value is arbitrary
`define ID_PREFIX 6'h2A
`define REG_CH_1_8 3'h0
`define REG_CH_9_16 3'h1
`define REG_CH_17_24 3'h2
`define REG_CH_25_32 3'h3
`define REG_CH_33_40 3'h4
`define REG_CONTROL 3'h5
`define REG_LAST 8'h05

`define CTL_PUMP_ON 7
`define CTL_TEST_HIGH 6
`define CTL_HALF_LEVEL 5
`define CTL_TEST_MID 4
`define CTL_LOAD 3
`define CTL_TEST_LOW 2
`define CTL_REF_HI 1
`define CTL_REF_LO 0

`define SEG_COUNT 36
`define CHAN_COUNT 40
`define CLK_FREQ_HZ 10000000
`define LOAD_HOLD_NS 1000
// One microsecond of load hold at the 10 MHz clock, sized for the hold counter
`define LOAD_HOLD_CYC 4'hA

`endif

// ==== hw/epd_sync_edge.v ====
// Two-flop synchroniser with rise and fall detection on the synchronised level.
// Assumes the input is asynchronous to clk.
`timescale 1ns/10ps
`default_nettype none
module epd_sync_edge (
   input wire clk,
   input wire rst_n,
   input wire async_in,
   output wire level,
   output wire rise,
   output wire fall
);
   reg meta_ff;
   reg sync_ff;
   reg last_ff;
   // First stage feeds only the second stage
   always @(posedge clk) begin
      if (!rst_n) begin
         meta_ff <= 1'b1;
         sync_ff <= 1'b1;
         last_ff <= 1'b1;
      end else begin
         meta_ff <= async_in;
         sync_ff <= meta_ff;
         last_ff <= sync_ff;
      end
   end
   assign level = sync_ff;
   assign rise = sync_ff & ~last_ff;
   assign fall = ~sync_ff & last_ff;
endmodule
`default_nettype wire

// ==== hw/epd_output_stage.v ====
// Staging buffer and output latch for the forty channels.
// Assumes channel and control bits arrive from registers on the same clock.
`timescale 1ns/10ps
`default_nettype none
`include "epd_ctrl_map.vh"
module epd_output_stage (
   input wire clk,
   input wire rst_n,
   input wire [39:0] chan_bits,
   input wire load,
   output reg [39:0] drive_high,
   output wire load_held
);
   reg [39:0] stage_ff;
   reg load_ff;
   reg [3:0] hold_cnt_ff;
   localparam [3:0] HOLD_MAX = `LOAD_HOLD_CYC;
   always @(posedge clk) begin
      if (!rst_n) begin
         stage_ff <= 40'h0000000000;
         drive_high <= 40'h0000000000;
         load_ff <= 1'b0;
         hold_cnt_ff <= 4'h0;
      end else begin
         load_ff <= load;
         if (load) begin
            stage_ff <= chan_bits;
            if (hold_cnt_ff != HOLD_MAX)
               hold_cnt_ff <= hold_cnt_ff + 4'h1;
         end else begin
            hold_cnt_ff <= 4'h0;
         end
         // Falling load moves the whole buffer at once, so outputs never tear
         if (load_ff && !load)
            drive_high <= stage_ff;
      end
   end
   // Status only: the host is trusted to keep the hold time
   assign load_held = (hold_cnt_ff == HOLD_MAX);
endmodule
`default_nettype wire

// ==== hw/epd_channel_control_regs.v ====
// Serial write link slave and register bank of the forty-channel driver.
// Assumes a host drives the serial clock and data line; the data pin is open
// drain with an external pull-up, and serial clock is far slower than clk.
`timescale 1ns/10ps
`default_nettype none
`include "epd_ctrl_map.vh"
module epd_channel_control_regs (
   input wire clk,
   input wire rst_n,
   input wire ser_clk,
   input wire ser_data_in,
   output wire ser_data_out,
   output wire ser_data_oe,
   input wire id_pin_high,
   input wire id_pin_low,
   output wire [39:0] chan_drive_high,
   output wire [39:0] chan_half_level,
   output wire [35:0] seg_drive,
   output wire [1:0] bg_drive,
   output wire [1:0] com_drive,
   output wire pump_on,
   output wire half_level_select,
   output wire [1:0] reference_select,
   output wire [2:0] test_bits,
   output wire load_held
);
   ////////////////////////////////////////////////////////////////////////////
   // Pin sampling
   wire scl_lvl;
   wire scl_rise;
   wire scl_fall;
   wire sda_lvl;
   wire sda_rise;
   wire sda_fall;
   wire pin_high_lvl;
   wire pin_low_lvl;

   epd_sync_edge u_scl (
      .clk(clk),
      .rst_n(rst_n),
      .async_in(ser_clk),
      .level(scl_lvl),
      .rise(scl_rise),
      .fall(scl_fall)
   );
   epd_sync_edge u_sda (
      .clk(clk),
      .rst_n(rst_n),
      .async_in(ser_data_in),
      .level(sda_lvl),
      .rise(sda_rise),
      .fall(sda_fall)
   );
   epd_sync_edge u_idh (
      .clk(clk),
      .rst_n(rst_n),
      .async_in(id_pin_high),
      .level(pin_high_lvl),
      .rise(),
      .fall()
   );
   epd_sync_edge u_idl (
      .clk(clk),
      .rst_n(rst_n),
      .async_in(id_pin_low),
      .level(pin_low_lvl),
      .rise(),
      .fall()
   );

   // Start: data falls with clock high; stop: data rises with clock high
   wire start_cond = sda_fall & scl_lvl;
   wire stop_cond = sda_rise & scl_lvl;

   ////////////////////////////////////////////////////////////////////////////
   // Byte receiver
   localparam [4:0] ST_IDLE = 5'h01;
   localparam [4:0] ST_BITS = 5'h02;
   localparam [4:0] ST_ACK = 5'h04;
   localparam [4:0] ST_ACKEND = 5'h08;
   localparam [4:0] ST_IGNORE = 5'h10;

   reg [4:0] state_ff;
   reg [4:0] nxt_state;
   reg [7:0] shift_ff;
   reg [7:0] nxt_shift;
   reg [2:0] bit_cnt_ff;
   reg [2:0] nxt_bit_cnt;
   reg [1:0] phase_ff;
   reg [1:0] nxt_phase;
   reg [7:0] addr_ff;
   reg [7:0] nxt_addr;
   reg ack_ff;
   reg nxt_ack;
   reg wr_en;
   reg [7:0] reg_file_ff [0:5];
   integer i;

   function id_match;
      input [7:0] b;
      input ph;
      input pl;
      begin
         id_match = (b == {`ID_PREFIX, ph, pl});
      end
   endfunction

   always @* begin
      nxt_state = state_ff;
      nxt_shift = shift_ff;
      nxt_bit_cnt = bit_cnt_ff;
      nxt_phase = phase_ff;
      nxt_addr = addr_ff;
      nxt_ack = ack_ff;
      wr_en = 1'b0;
      if (start_cond) begin
         nxt_state = ST_BITS;
         nxt_bit_cnt = 3'h0;
         nxt_phase = 2'h0;
         nxt_ack = 1'b0;
      end else if (stop_cond) begin
         nxt_state = ST_IDLE;
         nxt_ack = 1'b0;
      end else begin
         case (state_ff)
            ST_IDLE: begin
               nxt_state = ST_IDLE;
            end
            ST_BITS: begin
               if (scl_rise) begin
                  nxt_shift = {shift_ff[6:0], sda_lvl};
                  nxt_bit_cnt = bit_cnt_ff + 3'h1;
                  if (bit_cnt_ff == 3'h7)
                     nxt_state = ST_ACK;
               end
            end
            ST_ACK: begin
               // Eighth bit is in; act and drive acknowledge after clock falls
               if (scl_fall) begin
                  nxt_state = ST_ACKEND;
                  case (phase_ff)
                     2'h0: begin
                        if (id_match(shift_ff, pin_high_lvl, pin_low_lvl)) begin
                           nxt_ack = 1'b1;
                           nxt_phase = 2'h1;
                        end else begin
                           nxt_state = ST_IGNORE;
                        end
                     end
                     2'h1: begin
                        nxt_addr = shift_ff;
                        nxt_ack = 1'b1;
                        nxt_phase = 2'h2;
                     end
                     default: begin
                        wr_en = (addr_ff <= `REG_LAST);
                        nxt_ack = 1'b1;
                        // Stay in data phase so further bytes go to the next address
                        nxt_phase = 2'h2;
                        nxt_addr = addr_ff + 8'h01;
                     end
                  endcase
               end
            end
            ST_ACKEND: begin
               if (scl_fall) begin
                  nxt_ack = 1'b0;
                  nxt_state = ST_BITS;
                  nxt_bit_cnt = 3'h0;
               end
            end
            ST_IGNORE: begin
               // Another device owns this frame
               nxt_state = ST_IGNORE;
            end
            default: begin
               nxt_state = ST_IDLE;
            end
         endcase
      end
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         state_ff <= ST_IDLE;
         shift_ff <= 8'h00;
         bit_cnt_ff <= 3'h0;
         phase_ff <= 2'h0;
         addr_ff <= 8'h00;
         ack_ff <= 1'b0;
         // Clean start in simulation; the host must still initialise
         for (i = 0; i < 6; i = i + 1)
            reg_file_ff[i] <= 8'h00;
      end else begin
         state_ff <= nxt_state;
         shift_ff <= nxt_shift;
         bit_cnt_ff <= nxt_bit_cnt;
         phase_ff <= nxt_phase;
         addr_ff <= nxt_addr;
         ack_ff <= nxt_ack;
         if (wr_en)
            reg_file_ff[addr_ff[2:0]] <= shift_ff;
      end
   end

   // Open drain: only ever pull low
   assign ser_data_out = 1'b0;
   assign ser_data_oe = ack_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Register fields
   wire [7:0] ctl = reg_file_ff[`REG_CONTROL];
   wire [39:0] chan_bits = {reg_file_ff[`REG_CH_33_40], reg_file_ff[`REG_CH_25_32],
      reg_file_ff[`REG_CH_17_24], reg_file_ff[`REG_CH_9_16],
      reg_file_ff[`REG_CH_1_8]};

   assign pump_on = ctl[`CTL_PUMP_ON];
   assign half_level_select = ctl[`CTL_HALF_LEVEL];
   assign reference_select = {ctl[`CTL_REF_HI], ctl[`CTL_REF_LO]};
   // Test bits are exposed but steer nothing; host keeps them zero
   assign test_bits = {ctl[`CTL_TEST_HIGH], ctl[`CTL_TEST_MID], ctl[`CTL_TEST_LOW]};

   wire [39:0] drive_bits;
   epd_output_stage u_out (
      .clk(clk),
      .rst_n(rst_n),
      .chan_bits(chan_bits),
      .load(ctl[`CTL_LOAD]),
      .drive_high(drive_bits),
      .load_held(load_held)
   );

   assign chan_drive_high = drive_bits;
   assign chan_half_level = drive_bits & {`CHAN_COUNT{half_level_select}};
   assign seg_drive = drive_bits[`SEG_COUNT-1:0];
   assign bg_drive = drive_bits[37:36];
   assign com_drive = drive_bits[39:38];
endmodule
`default_nettype wire

// ==== tb/epd_host_model.sv ====
// Host side of the two-wire write link, open drain with pull-up.
// Assumes clk at 10 MHz; one serial bit is 8 clk, idle clock high.
`timescale 1ns/10ps
`default_nettype none
module epd_host_model (
   input wire logic clk,
   input wire logic sda,
   output logic scl,
   output logic sda_low
);
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   // Data moves 2 clk clear of each clock edge, so sync lag cannot fake a start
   task automatic send_byte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         sda_low <= ~b[i];
         tick(2);
         scl <= 1'b1;
         tick(4);
         scl <= 1'b0;
         tick(2);
      end
      sda_low <= 1'b0;
      tick(2);
      scl <= 1'b1;
      tick(2);
      ack = ~sda;
      tick(2);
      scl <= 1'b0;
      tick(2);
   endtask
   task automatic write(input logic [7:0] id, a, d, output logic ok);
      logic k1, k2, k3;
      sda_low <= 1'b1;
      tick(4);
      scl <= 1'b0;
      tick(2);
      send_byte(id, k1);
      send_byte(a, k2);
      send_byte(d, k3);
      sda_low <= 1'b1;
      tick(2);
      scl <= 1'b1;
      tick(4);
      sda_low <= 1'b0;
      tick(4);
      ok = k1 & k2 & k3;
   endtask
endmodule
`default_nettype wire

// ==== tb/epd_ctrl_regs_assertions.sv ====
// Checker for the channel control register bank.
// Assumes it is bound onto the design top and sees its ports only.
`timescale 1ns/10ps
`default_nettype none
module epd_ctrl_regs_checker (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ser_clk,
   input wire logic ser_data_out,
   input wire logic ser_data_oe,
   input wire logic [39:0] chan_drive_high,
   input wire logic [39:0] chan_half_level,
   input wire logic [35:0] seg_drive,
   input wire logic [1:0] bg_drive,
   input wire logic [1:0] com_drive,
   input wire logic pump_on,
   input wire logic half_level_select,
   input wire logic [1:0] reference_select,
   input wire logic load_held
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   a_seg_slice: assert property (seg_drive == chan_drive_high[35:0])
      else $error("segment slice wrong");
   a_edge_slices: assert property ({com_drive, bg_drive} == chan_drive_high[39:36])
      else $error("bg or com slice wrong");
   a_half_map: assert property
      (chan_half_level == (chan_drive_high & {40{half_level_select}}))
      else $error("half level map wrong");
   a_ack_low: assert property (ser_data_oe |-> !ser_data_out)
      else $error("ack not low");
   a_ack_span: assert property ($rose(ser_data_oe) |-> ser_data_oe[*5] ##[1:20] !ser_data_oe)
      else $error("ack length wrong");
   a_ack_clk_low: assert property ($rose(ser_data_oe) |-> !$past(ser_clk))
      else $error("ack while clock high");
   // Releasing the line with the clock high would look like a stop
   a_ack_release: assert property ($fell(ser_data_oe) |-> !$past(ser_clk))
      else $error("ack released while clock high");
   // Outputs only move once a held load has been cleared
   a_latch_cause: assert property ($changed(chan_drive_high) |->
      $past(load_held) || $past(load_held, 2) || $past(load_held, 3))
      else $error("outputs moved without latch");
   a_ctl_by_write: assert property
      ($changed({pump_on, half_level_select, reference_select}) |-> ##[0:4] ser_data_oe)
      else $error("control moved without write");
endmodule
bind epd_channel_control_regs epd_ctrl_regs_checker i_chk (.clk(clk), .rst_n(rst_n),
   .ser_clk(ser_clk), .ser_data_out(ser_data_out), .ser_data_oe(ser_data_oe),
   .chan_drive_high(chan_drive_high), .chan_half_level(chan_half_level),
   .seg_drive(seg_drive), .bg_drive(bg_drive), .com_drive(com_drive), .pump_on(pump_on),
   .half_level_select(half_level_select), .reference_select(reference_select),
   .load_held(load_held));
`default_nettype wire

// ==== tb/epd_channel_control_regs_test.sv ====
// Self-checking bench for the channel control register bank.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/10ps
`default_nettype none
`include "epd_ctrl_map.vh"
module epd_channel_control_regs_test;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic ok;
   logic id_hi = 1'b1;
   logic id_lo = 1'b0;
   // Pattern last latched onto the outputs; outputs start at zero
   logic [39:0] latched = 40'h0000000000;
   int err_count = 0;
   int checks_done = 0;
   wire scl, host_low, d_out, d_oe, lh, pump, half;
   wire [39:0] drv, hl;
   wire [35:0] seg;
   wire [1:0] bg, com, vref;
   wire [2:0] tst;
   // Pull-up wins unless someone pulls low
   wire sda = ~(host_low | (d_oe & ~d_out));
   always #50 clk = ~clk;
   epd_host_model i_host (.clk(clk), .sda(sda), .scl(scl), .sda_low(host_low));
   epd_channel_control_regs i_dut (.clk(clk), .rst_n(rst_n), .ser_clk(scl),
      .ser_data_in(sda), .ser_data_out(d_out), .ser_data_oe(d_oe), .id_pin_high(id_hi),
      .id_pin_low(id_lo), .chan_drive_high(drv), .chan_half_level(hl), .seg_drive(seg),
      .bg_drive(bg), .com_drive(com), .pump_on(pump), .half_level_select(half),
      .reference_select(vref), .test_bits(tst), .load_held(lh));
   ////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [39:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, d);
      i_host.write({`ID_PREFIX, 2'b10}, a, d, ok);
      chk("ack", ok, 1'b1);
   endtask
   // Test bits of every control value are kept zero
   task automatic show(input logic [39:0] ch, input logic [7:0] ctl);
      for (int r = 0; r < 5; r++) begin
         wr(r[7:0], ch[r*8+:8]);
      end
      wr(8'h05, ctl | 8'h08);
      chk("held", lh, 1'b1);
      chk("wait", drv, latched);
      wr(8'h05, ctl);
      latched = ch;
      chk("out", drv, ch);
      chk("map", {com, bg, seg}, ch);
      chk("half", hl, ch & {40{ctl[5]}});
      chk("halfsel", half, ctl[5]);
      chk("pump", pump, ctl[7]);
      chk("test", tst, 3'h0);
   endtask
   task automatic complete_run;
      $display("Mismatches %0d of %0d checks", err_count, checks_done);
      if (err_count == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      repeat (5) @(posedge clk);
      show(40'h0000000000, 8'h80);
      // Pump settle wait shortened to keep the run short
      repeat (200) @(posedge clk);
      show(40'hC35A0F9681, 8'h80);
      show(40'h3CA5F0697E, 8'hA0);
      wr(8'h00, 8'hFF);
      chk("keep", drv, 40'h3CA5F0697E);
      // Pump stays on while channels are high
      for (int v = 0; v < 4; v++) begin
         wr(8'h05, {6'h28, v[1:0]});
         chk("vref", vref, v[1:0]);
      end
      chk("pump", pump, 1'b1);
      wr(8'h06, 8'h00);
      wr(8'h0D, 8'h00);
      chk("hole", {pump, vref}, 3'h7);
      i_host.write({`ID_PREFIX, 2'b01}, 8'h05, 8'hA1, ok);
      chk("nack", ok, 1'b0);
      chk("other", vref, 2'h3);
      id_hi <= 1'b0;
      id_lo <= 1'b1;
      repeat (4) @(posedge clk);
      i_host.write({`ID_PREFIX, 2'b01}, 8'h05, 8'hA1, ok);
      chk("pins", ok, 1'b1);
      chk("moved", vref, 2'h1);
      id_hi <= 1'b1;
      id_lo <= 1'b0;
      repeat (4) @(posedge clk);
      show(40'h0000000000, 8'h80);
      wr(8'h05, 8'h00);
      chk("off", pump, 1'b0);
      complete_run;
   end
   initial begin
      #3000000;
      err_count++;
      complete_run;
   end
endmodule
`default_nettype wire
